// ==== hw/scx_pkg.sv ====
// Shared constants and types of the segment expander core.
// Assumes a single 200 MHz clock; all times below are turned into cycles.
package scx_pkg;
    // Lane order: data 0..15, parity 16..17, then the control signals.
    localparam int NL = 27;
    localparam int L_REQ = 18;
    localparam int L_ACK = 19;
    localparam int L_BSY = 20;
    localparam int L_SEL = 21;
    localparam int L_RST = 22;
    localparam int L_CD = 23;
    localparam int L_IO = 24;
    localparam int L_MSG = 25;
    localparam int L_ATN = 26;
    // Lanes that are driven deasserted instead of released to terminators.
    localparam logic [NL-1:0] ACT_NEG_MASK = 27'h00FFFFF;

    localparam int CLK_MHZ = 200;
    localparam int MAX_RATE_MBS = 40;
    localparam int DLY_W = 8;
    localparam int HOLD_NS = 10;
    localparam int BSY_BIG_NS = 400;
    localparam int NEG_NS = 10;
    localparam int REC_NS = 10;
    localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int BSY_BIG_CYC = (BSY_BIG_NS * CLK_MHZ + 999) / 1000;
    localparam int NEG_CYC = (NEG_NS * CLK_MHZ + 999) / 1000;
    localparam int REC_CYC = (REC_NS * CLK_MHZ + 999) / 1000;
    localparam logic [DLY_W-1:0] SETUP_DLY_RST = 8'h04;

    localparam int QUAL_MS = 100;
    localparam int RST_PULSE_US = 25;
    localparam int CAL_PERIOD_US = 1000;
    localparam int QUAL_CYC = QUAL_MS * 1000 * CLK_MHZ;
    localparam int RST_PULSE_CYC = RST_PULSE_US * CLK_MHZ;
    localparam int CAL_CYC = CAL_PERIOD_US * CLK_MHZ;

    typedef enum logic [3:0] {
        LN_IDLE = 4'b0001,
        LN_FWD = 4'b0010,
        LN_NEG = 4'b0100,
        LN_REC = 4'b1000
    } scx_lane_st_t;

    typedef enum logic [4:0] {
        PH_IDLE = 5'b00001,
        PH_ARB = 5'b00010,
        PH_SEL = 5'b00100,
        PH_INFO = 5'b01000,
        PH_RST = 5'b10000
    } scx_phase_t;
endpackage : scx_pkg

// ==== hw/scx_lane.sv ====
// One bidirectional signal lane between the A and B segments.
// Assumes pin levels are already synchronous and read 1 when asserted.
`timescale 1ns/1ps
module scx_lane #(
    parameter bit ACT_NEG = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic a_in,
    input wire logic b_in,
    input wire logic en_ab,
    input wire logic en_ba,
    input wire logic [scx_pkg::DLY_W-1:0] lead_dly,
    input wire logic [scx_pkg::DLY_W-1:0] hold_min,
    output logic a_out,
    output logic a_oe,
    output logic b_out,
    output logic b_oe,
    output logic src_a
);
    import scx_pkg::*;

    scx_lane_st_t st_r, st_nxt;
    logic dir_a_r, dir_a_nxt;
    logic [DLY_W:0] cnt_r, cnt_nxt;
    logic a_q_r, b_q_r;
    logic out_r, out_nxt;
    logic oe_r, oe_nxt;
    logic a_ok, b_ok, src_lvl;
    logic [DLY_W:0] lead_x, done_x;

    // Two agreeing samples are needed; one-cycle spikes never pass.
    assign a_ok = a_in & a_q_r;
    assign b_ok = b_in & b_q_r;
    assign src_lvl = dir_a_r ? a_in : b_in;
    assign lead_x = {1'b0, lead_dly};
    assign done_x = lead_x + {1'b0, hold_min};

    always_comb begin
        st_nxt = st_r;
        dir_a_nxt = dir_a_r;
        cnt_nxt = cnt_r;
        case (st_r)
            LN_IDLE: begin
                cnt_nxt = '0;
                if (a_ok && en_ab) begin
                    st_nxt = LN_FWD;
                    dir_a_nxt = 1'b1;
                end else if (b_ok && en_ba) begin
                    st_nxt = LN_FWD;
                    dir_a_nxt = 1'b0;
                end
            end
            LN_FWD: begin
                if (cnt_r != {(DLY_W+1){1'b1}}) begin
                    cnt_nxt = cnt_r + 1'b1;
                end
                // The far side is ours, so only the source pin is read.
                if (!src_lvl && cnt_r >= done_x) begin
                    st_nxt = ACT_NEG ? LN_NEG : LN_REC;
                    cnt_nxt = '0;
                end
            end
            LN_NEG: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == (DLY_W+1)'(NEG_CYC - 1)) begin
                    st_nxt = LN_REC;
                    cnt_nxt = '0;
                end
            end
            LN_REC: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == (DLY_W+1)'(REC_CYC - 1)) begin
                    st_nxt = LN_IDLE;
                    cnt_nxt = '0;
                end
            end
            default: begin
                st_nxt = LN_IDLE;
                cnt_nxt = '0;
            end
        endcase
        // Assertion edge is moved by lead_dly to give the load setup time.
        oe_nxt = (st_nxt == LN_FWD) || (st_nxt == LN_NEG);
        out_nxt = (st_nxt == LN_FWD) && (cnt_nxt >= lead_x);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= LN_IDLE;
            dir_a_r <= 1'b0;
            cnt_r <= '0;
            a_q_r <= 1'b0;
            b_q_r <= 1'b0;
            out_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            dir_a_r <= dir_a_nxt;
            cnt_r <= cnt_nxt;
            a_q_r <= a_in;
            b_q_r <= b_in;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
        end
    end

    // Only the load side is ever enabled.
    assign b_out = out_r & dir_a_r;
    assign b_oe = oe_r & dir_a_r;
    assign a_out = out_r & ~dir_a_r;
    assign a_oe = oe_r & ~dir_a_r;
    assign src_a = dir_a_r;
endmodule : scx_lane

// ==== hw/scx_core.sv ====
// Top of the two-segment repeater: 27 signal lanes, phase tracking,
// sense-line qualification, A-side reset injection and delay calibration.
// Assumes pins are pre-synchronised and read 1 when a signal is asserted.
`timescale 1ns/1ps
module scx_core #(
    parameter int QUAL_CYCLES = scx_pkg::QUAL_CYC,
    parameter int RST_CYCLES = scx_pkg::RST_PULSE_CYC,
    parameter int CAL_CYCLES = scx_pkg::CAL_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [scx_pkg::NL-1:0] a_in,
    input wire logic [scx_pkg::NL-1:0] b_in,
    input wire logic b_diffsens_lvd,
    input wire logic [scx_pkg::DLY_W-1:0] delay_trim,
    output logic [scx_pkg::NL-1:0] a_out,
    output logic [scx_pkg::NL-1:0] a_oe,
    output logic [scx_pkg::NL-1:0] b_out,
    output logic [scx_pkg::NL-1:0] b_oe,
    output logic b_lvd_mode
);
    import scx_pkg::*;

    // There is no register port: behaviour follows bus signals and the delay_trim input.

    logic ds_s1_r, ds_s2_r;
    logic mode_r, mode_nxt;
    logic [31:0] qual_cnt_r, qual_cnt_nxt;
    logic chg;
    logic [31:0] inj_cnt_r, inj_cnt_nxt;
    logic inj;
    logic [31:0] cal_cnt_r, cal_cnt_nxt;
    logic cal_tick;
    logic [DLY_W-1:0] setup_dly_r, setup_dly_nxt;
    scx_phase_t ph_r, ph_nxt;
    logic init_a_r, init_a_nxt;

    logic [NL-1:0] bus_v, en_ab, en_ba, lane_a_in, src_a;
    logic [NL-1:0] la_out, la_oe;
    logic [DLY_W-1:0] lead [NL];
    logic [DLY_W-1:0] hold [NL];
    logic data_clk;

    // Sense line crossing: stage one feeds stage two only.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ds_s1_r <= 1'b0;
            ds_s2_r <= 1'b0;
        end else begin
            ds_s1_r <= b_diffsens_lvd;
            ds_s2_r <= ds_s1_r;
        end
    end

    // A level that differs from the current mode must stay for the full
    // qualification time; any return to the old level restarts the count.
    always_comb begin
        mode_nxt = mode_r;
        qual_cnt_nxt = '0;
        chg = 1'b0;
        if (ds_s2_r != mode_r) begin
            if (qual_cnt_r == 32'(QUAL_CYCLES - 1)) begin
                mode_nxt = ds_s2_r;
                chg = 1'b1;
            end else begin
                qual_cnt_nxt = qual_cnt_r + 32'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= 1'b0;
            qual_cnt_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            qual_cnt_r <= qual_cnt_nxt;
        end
    end

    assign b_lvd_mode = mode_r;

    // Reset pulse on the A segment after a qualified mode change.
    always_comb begin
        inj_cnt_nxt = inj_cnt_r;
        if (chg) begin
            inj_cnt_nxt = 32'(RST_CYCLES);
        end else if (inj_cnt_r != '0) begin
            inj_cnt_nxt = inj_cnt_r - 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inj_cnt_r <= '0;
        end else begin
            inj_cnt_r <= inj_cnt_nxt;
        end
    end

    assign inj = (inj_cnt_r != '0);

    // Delay calibration: the trim value is sampled only on the periodic
    // tick, so a setting stays fixed for a whole calibration period.
    always_comb begin
        cal_tick = (cal_cnt_r == 32'(CAL_CYCLES - 1));
        cal_cnt_nxt = cal_tick ? '0 : cal_cnt_r + 32'h1;
        setup_dly_nxt = cal_tick ? delay_trim : setup_dly_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_cnt_r <= '0;
            setup_dly_r <= SETUP_DLY_RST;
        end else begin
            cal_cnt_r <= cal_cnt_nxt;
            setup_dly_r <= setup_dly_nxt;
        end
    end

    // Bus phase tracking on the wire levels of both segments.
    assign bus_v = a_in | b_in;

    always_comb begin
        ph_nxt = ph_r;
        init_a_nxt = init_a_r;
        if (bus_v[L_RST]) begin
            ph_nxt = PH_RST;
        end else begin
            case (ph_r)
                PH_IDLE: begin
                    if (bus_v[L_SEL]) begin
                        ph_nxt = PH_SEL;
                    end else if (bus_v[L_BSY]) begin
                        ph_nxt = PH_ARB;
                    end
                end
                PH_ARB: begin
                    if (bus_v[L_SEL]) begin
                        ph_nxt = PH_SEL;
                    end else if (!bus_v[L_BSY]) begin
                        ph_nxt = PH_IDLE;
                    end
                end
                PH_SEL: begin
                    if (!bus_v[L_SEL]) begin
                        ph_nxt = bus_v[L_BSY] ? PH_INFO : PH_IDLE;
                    end
                end
                PH_INFO: begin
                    if (!bus_v[L_BSY]) begin
                        ph_nxt = PH_IDLE;
                    end
                end
                PH_RST: begin
                    ph_nxt = PH_IDLE;
                end
                default: begin
                    ph_nxt = PH_IDLE;
                end
            endcase
        end
        // The side that drove SEL holds the initiator.
        if (ph_r == PH_SEL && src_a[L_SEL] != init_a_r) begin
            init_a_nxt = src_a[L_SEL];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_r <= PH_IDLE;
            init_a_r <= 1'b1;
        end else begin
            ph_r <= ph_nxt;
            init_a_r <= init_a_nxt;
        end
    end

    assign data_clk = (ph_r == PH_INFO) && !bus_v[L_CD] && !bus_v[L_MSG];

    // Per-lane handling derived from the phase.
    always_comb begin
        en_ab = '1;
        en_ba = '1;
        for (int i = 0; i < NL; i++) begin
            lead[i] = '0;
            hold[i] = DLY_W'(HOLD_CYC);
        end
        if (ph_r == PH_INFO) begin
            en_ab[L_REQ] = !init_a_r;
            en_ba[L_REQ] = init_a_r;
            en_ab[L_ACK] = init_a_r;
            en_ba[L_ACK] = !init_a_r;
            for (int i = 0; i < L_REQ; i++) begin
                en_ab[i] = bus_v[L_IO] ? !init_a_r : init_a_r;
                en_ba[i] = bus_v[L_IO] ? init_a_r : !init_a_r;
            end
        end
        if (data_clk) begin
            lead[L_REQ] = setup_dly_r;
            lead[L_ACK] = setup_dly_r;
        end
        // Wide filter while BSY and SEL may change sides.
        if (ph_r == PH_SEL || ph_r == PH_ARB) begin
            hold[L_BSY] = DLY_W'(BSY_BIG_CYC);
        end
    end

    // Our own A reset must not be read back as an A-side source.
    always_comb begin
        lane_a_in = a_in;
        lane_a_in[L_RST] = a_in[L_RST] & ~inj;
    end

    generate
        for (genvar g = 0; g < NL; g++) begin : g_lane
            scx_lane #(
                .ACT_NEG(ACT_NEG_MASK[g])
            ) u_lane (
                .clk(clk),
                .rst_n(rst_n),
                .a_in(lane_a_in[g]),
                .b_in(b_in[g]),
                .en_ab(en_ab[g]),
                .en_ba(en_ba[g]),
                .lead_dly(lead[g]),
                .hold_min(hold[g]),
                .a_out(la_out[g]),
                .a_oe(la_oe[g]),
                .b_out(b_out[g]),
                .b_oe(b_oe[g]),
                .src_a(src_a[g])
            );
        end
    endgenerate

    // The generated reset joins the normal A-side reset driver.
    assign a_out = la_out | (NL'(inj) << L_RST);
    assign a_oe = la_oe | (NL'(inj) << L_RST);

    a_mode_qual: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(mode_r) |-> $past(qual_cnt_r) == 32'(QUAL_CYCLES - 1)
        && $past(ds_s2_r) == mode_r)
        else $error("mode changed before qualification");

    a_qual_restart: assert property (@(posedge clk) disable iff (!rst_n)
        ds_s2_r == mode_r |=> qual_cnt_r == '0)
        else $error("qualify counter not restarted");

    a_inj_start: assert property (@(posedge clk) disable iff (!rst_n)
        chg |=> a_oe[L_RST] && a_out[L_RST] && inj)
        else $error("no A reset after mode change");

    a_no_echo: assert property (@(posedge clk) disable iff (!rst_n)
        inj [*8] |-> !b_out[L_RST])
        else $error("generated reset echoed to B");

    a_one_side: assert property (@(posedge clk) disable iff (!rst_n)
        (la_oe & b_oe) == '0)
        else $error("both sides driven on one lane");

    a_reset_idle: assert property (@(posedge clk)
        $rose(rst_n) |-> a_oe == '0 && b_oe == '0 && ph_r == PH_IDLE)
        else $error("outputs active after reset");

    a_cal_load: assert property (@(posedge clk) disable iff (!rst_n)
        cal_tick |=> setup_dly_r == $past(delay_trim))
        else $error("delay setting not refreshed");

    a_neg_drive: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(b_out[0]) && $past(b_oe[0]) |-> b_oe[0])
        else $error("data released instead of negated");

    a_glitch_fwd: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(b_oe[0]) |-> $past(a_in[0], 1) && $past(a_in[0], 2))
        else $error("single sample forwarded");

    c_mode_change: cover property (@(posedge clk) disable iff (!rst_n)
        chg);
    c_info_b_init: cover property (@(posedge clk) disable iff (!rst_n)
        ph_r == PH_INFO && !init_a_r);
    c_data_clk: cover property (@(posedge clk) disable iff (!rst_n)
        data_clk && b_oe[L_ACK]);
endmodule : scx_core

// ==== tb/scx_seg_model.sv ====
// Model of the two cable segments with their initiators and targets.
// Assumes pin bits read 1 when asserted; terminators pull released lines
// to the deasserted level, so an undriven wire reads 0.
`timescale 1ns/1ps
module scx_seg_model (
    input wire logic [scx_pkg::NL-1:0] dev_a,
    input wire logic [scx_pkg::NL-1:0] dev_b,
    input wire logic [scx_pkg::NL-1:0] a_out,
    input wire logic [scx_pkg::NL-1:0] a_oe,
    input wire logic [scx_pkg::NL-1:0] b_out,
    input wire logic [scx_pkg::NL-1:0] b_oe,
    output logic [scx_pkg::NL-1:0] a_in,
    output logic [scx_pkg::NL-1:0] b_in
);
    import scx_pkg::*;

    // Wired-OR of the far devices and the expander, so the core also sees
    // its own drive and must not take it for an incoming signal.
    assign a_in = dev_a | (a_oe & a_out);
    assign b_in = dev_b | (b_oe & b_out);
endmodule : scx_seg_model

// ==== tb/scx_core_bench.sv ====
// Self-checking bench for the segment expander core.
// Assumes the shortened sim counts QUAL 50, RST 10 and CAL 20 cycles.
`timescale 1ns/1ps
module scx_core_bench;
    import scx_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic lvd_sense = 1'b0;
    logic [DLY_W-1:0] trim = 8'h06;
    logic [NL-1:0] dev_a = '0;
    logic [NL-1:0] dev_b = '0;
    logic [NL-1:0] a_in;
    logic [NL-1:0] b_in;
    logic [NL-1:0] a_out;
    logic [NL-1:0] a_oe;
    logic [NL-1:0] b_out;
    logic [NL-1:0] b_oe;
    logic lvd_mode;
    int n_fail = 0;
    int compares = 0;

    always #2.5 clk = ~clk;

    scx_core #(.QUAL_CYCLES(50), .RST_CYCLES(10), .CAL_CYCLES(20)) dut (
        .clk(clk), .rst_n(rst_n), .a_in(a_in), .b_in(b_in),
        .b_diffsens_lvd(lvd_sense), .delay_trim(trim), .a_out(a_out),
        .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .b_lvd_mode(lvd_mode)
    );

    scx_seg_model segs (
        .dev_a(dev_a), .dev_b(dev_b), .a_out(a_out), .a_oe(a_oe),
        .b_out(b_out), .b_oe(b_oe), .a_in(a_in), .b_in(b_in)
    );

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task stop_test;
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // Selector: 0 b_oe, 1 b_out, 2 a_oe, 3 a_out.
    function automatic logic pick(input int w, input int l);
        case (w)
            0: return b_oe[l];
            1: return b_out[l];
            2: return a_oe[l];
            default: return a_out[l];
        endcase
    endfunction : pick

    task wait_bit(input int w, input int l, input logic lvl, output int k);
        k = 0;
        while (pick(w, l) !== lvl && k < 120) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask : wait_bit

    // One assertion carried across and released, from either side.
    task fwd(input logic from_a, input int lane);
        int k;
        int lw;
        lw = from_a ? 0 : 2;
        @(posedge clk);
        if (from_a) dev_a[lane] <= 1'b1;
        else dev_b[lane] <= 1'b1;
        wait_bit(lw, lane, 1'b1, k);
        check(32'(pick(lw + 1, lane)), 32'h1);
        check(32'(pick(2 - lw, lane)), 32'h0);
        @(posedge clk);
        if (from_a) dev_a[lane] <= 1'b0;
        else dev_b[lane] <= 1'b0;
        #1;
        wait_bit(lw + 1, lane, 1'b0, k);
        // Lanes without active negation must let go at once.
        if (ACT_NEG_MASK[lane]) check(32'(pick(lw, lane)), 32'h1);
        else check(32'(pick(lw, lane)), 32'h0);
        wait_bit(lw, lane, 1'b0, k);
        check(32'(k < 120), 32'h1);
        repeat (4) @(posedge clk);
    endtask : fwd

    // A one-cycle spike must never reach the far segment.
    task spike;
        @(posedge clk);
        dev_a[3] <= 1'b1;
        @(posedge clk);
        dev_a[3] <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check(32'(b_oe[3]), 32'h0);
    endtask : spike

    task mid_reset;
        int k;
        @(posedge clk);
        dev_a[1] <= 1'b1;
        wait_bit(0, 1, 1'b1, k);
        @(posedge clk);
        rst_n <= 1'b0;
        dev_a[1] <= 1'b0;
        #1;
        check(32'(a_oe), 32'h0);
        check(32'(b_oe), 32'h0);
        check(32'(a_out | b_out), 32'h0);
        check(32'(lvd_mode), 32'h0);
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(32'(a_oe | b_oe), 32'h0);
    endtask : mid_reset

    // Data-out phase with the initiator on A: ACK is held back by the
    // calibrated setup delay, REQ from A and data from B are refused.
    task info_phase;
        int k;
        @(posedge clk);
        dev_a[L_SEL] <= 1'b1;
        repeat (4) @(posedge clk);
        dev_b[L_BSY] <= 1'b1;
        repeat (4) @(posedge clk);
        dev_a[L_SEL] <= 1'b0;
        repeat (8) @(posedge clk);
        dev_a[L_ACK:L_REQ] <= 2'b11;
        dev_b[0] <= 1'b1;
        wait_bit(0, L_ACK, 1'b1, k);
        wait_bit(1, L_ACK, 1'b1, k);
        check(32'(k), 32'(trim));
        check(32'(b_oe[L_REQ]), 32'h0);
        check(32'(a_oe[0]), 32'h0);
        @(posedge clk);
        dev_a[L_ACK:L_REQ] <= 2'b00;
        dev_b[0] <= 1'b0;
        @(posedge clk);
        dev_b[L_BSY] <= 1'b0;
        repeat (12) @(posedge clk);
    endtask : info_phase

    // Sense change qualified, then A reset injected and kept off B.
    task mode_change;
        int k;
        @(posedge clk);
        lvd_sense <= 1'b1;
        #1;
        k = 0;
        while (lvd_mode !== 1'b1 && k < 80) begin
            @(posedge clk);
            #1;
            k++;
        end
        check(32'(k >= 50 && k <= 56), 32'h1);
        @(posedge clk);
        #1;
        check(32'({a_oe[L_RST], a_out[L_RST]}), 32'h3);
        repeat (12) begin
            check(32'(b_oe[L_RST]), 32'h0);
            @(posedge clk);
            #1;
        end
        check(32'(a_oe[L_RST]), 32'h0);
        // A short return to the old level must restart the count, so two
        // 30-cycle stretches never add up to a mode change.
        @(posedge clk);
        lvd_sense <= 1'b0;
        repeat (30) @(posedge clk);
        lvd_sense <= 1'b1;
        repeat (5) @(posedge clk);
        lvd_sense <= 1'b0;
        repeat (30) @(posedge clk);
        #1;
        check(32'(lvd_mode), 32'h1);
        repeat (25) @(posedge clk);
        #1;
        check(32'(lvd_mode), 32'h0);
        check(32'({a_oe[L_RST], a_out[L_RST]}), 32'h3);
        repeat (12) @(posedge clk);
    endtask : mode_change

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check(32'(a_oe), 32'h0);
        check(32'(b_oe), 32'h0);
        check(32'(lvd_mode), 32'h0);
        fwd(1'b1, 0);
        fwd(1'b0, 5);
        fwd(1'b1, 16);
        fwd(1'b1, 20);
        spike();
        info_phase();
        mid_reset();
        mode_change();
        fwd(1'b1, 2); // Data lane 2 from A still forwards after the injected reset.
        stop_test();
    end

    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        stop_test();
    end
endmodule : scx_core_bench
